/* File: hw/power_gating_params.svh */
`ifndef POWER_GATING_PARAMS_SVH
`define POWER_GATING_PARAMS_SVH

// Width of the power-mode code and counts of grouped sources.
`define PG_MODE_W 4
`define PG_NUM_OSC_REQ 8
`define PG_NUM_SERIAL 6
`define PG_NUM_TWI 3
`define PG_NUM_WKUP_PINS 5
`define PG_NUM_TAMPER 3
`define PG_NUM_BREAK_SRC 7
`define PG_NUM_LPTIM 2

// Index of the serial port and two-wire interface that survive Stop 2.
`define PG_LPSERIAL_IDX 5
`define PG_TWI_DEEP_IDX 2

// Reset values of the control outputs.
`define PG_FLASH_PD_RST 1'b0
`define PG_IO_ANALOG_RST 1'b1

`endif

/* File: hw/power_gating_pkg.sv */
package power_gating_pkg;

	typedef enum logic [3:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_LP_RUN,
		MODE_LP_SLEEP,
		MODE_STOP0,
		MODE_STOP1,
		MODE_STOP2,
		MODE_STANDBY,
		MODE_SHUTDOWN,
		MODE_BATTERY
	} power_mode_t;

	typedef struct packed {
		logic rngEn;
		logic dmaEn;
		logic flashPdReq;
		logic sram2RetainSel;
		logic [1:0] lptimEn;
		logic supplyDetEn;
	} sw_enable_t;

	typedef struct packed {
		logic timerSync;
		logic convTrig;
		logic memTrig;
		logic compBlank;
		logic timerBreak;
		logic [1:0] compToLptim;
		logic [1:0] rtcToLptim;
	} trigger_gate_t;

endpackage : power_gating_pkg

/* File: hw/osc_request_slot.sv */
`timescale 1ns/100ps
`include "power_gating_params.svh"

// One requester slot of the on-demand fast oscillator.
module osc_request_slot
	import power_gating_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic inStop,
	input wire logic capable,
	input wire logic request,
	output logic granted
);

	logic next_granted;

	always_comb begin
		next_granted = inStop && capable && request;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			granted <= 1'b0;
		end else begin
			granted <= next_granted;
		end
	end

endmodule : osc_request_slot

/* File: hw/power_mode_gating_wakeup.sv */
`timescale 1ns/100ps
`include "power_gating_params.svh"

// Functional notes
// - Stop-wake peripherals may request fast oscillator.
// - On-demand oscillator clock feeds only requester.
// - Oscillator drops when no requester remains.
// - Serial receivers wake on start/address/frame.
// - Two-wire address match wakes from Stop.
// - Standby keeps RAM bank only if selected.
// - Random generator: run/sleep, range 1 only.
// - Flash leaves reset powered; software power-down.
// - Optional functions off until software enables.
// - I/O analog through reset; triggers on in Run.
// - Internal reset source disables reset pull-up.
// - No main supply forces battery operation.
// - Battery operation ignores interrupts and alarms.
// - Three tampers always on, never wake.
// - Comparator-to-timer path; Stop 2 timer A only.
// - Clock alarm-to-timer path; Stop 2 timer A.
// - Timer interlinks only in run/sleep and low-power run/sleep.
// - Timer break sources gated in run/sleep.
// - Timer B wakes in Stop 0/1 only.
// - Low-power serial, third two-wire wake Stop 2.
// - Exactly five pins wake Standby/Shutdown.
// - Shutdown pull configuration discarded on exit.
module power_mode_gating_wakeup
	import power_gating_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire power_mode_t modeReq,
	input wire logic mainSupplyOk,
	input wire logic coreRange1,
	input wire sw_enable_t swEn,
	input wire logic internalResetSrc,
	input wire logic [`PG_NUM_OSC_REQ-1:0] oscCapable,
	input wire logic [`PG_NUM_OSC_REQ-1:0] oscRequest,
	input wire logic [`PG_NUM_SERIAL-1:0] serialEvent,
	input wire logic [`PG_NUM_TWI-1:0] twiAddrMatch,
	input wire logic [`PG_NUM_LPTIM-1:0] lptimEvent,
	input wire logic [`PG_NUM_WKUP_PINS-1:0] wakePinEvent,
	input wire logic extIrq,
	input wire logic rtcEvent,
	input wire logic [`PG_NUM_TAMPER-1:0] tamperIn,
	input wire logic [`PG_NUM_BREAK_SRC-1:0] breakSrc,
	input wire logic [1:0] pullCfgIn,
	output power_mode_t mode,
	output logic fastOscOn,
	output logic [`PG_NUM_OSC_REQ-1:0] fastOscGate,
	output logic [`PG_NUM_SERIAL-1:0] serialRun,
	output logic [`PG_NUM_TWI-1:0] twiRun,
	output logic [`PG_NUM_LPTIM-1:0] lptimRun,
	output logic wakeupReq,
	output logic sram2Retain,
	output logic rngAllow,
	output logic flashPowerDown,
	output logic dmaAllow,
	output logic supplyDetAllow,
	output logic ioAnalog,
	output logic resetPullupOn,
	output logic [2:0] batterySupplied,
	output logic [`PG_NUM_TAMPER-1:0] tamperActive,
	output trigger_gate_t trigGate,
	output logic timerBreak,
	output logic [1:0] pullCfgHold
);

	////////////////////////////////////////////////////////////////
	// Mode register.

	power_mode_t next_mode;
	logic next_flashPowerDown;
	logic next_ioAnalog;
	logic next_resetPullupOn;
	logic [1:0] next_pullCfgHold;

	always_comb begin
		next_mode = modeReq;
		if (!mainSupplyOk) begin
			next_mode = MODE_BATTERY;
		end else if (mode == MODE_BATTERY) begin
			// Only the supply's return lifts battery operation.
			next_mode = MODE_RUN;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode <= MODE_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	////////////////////////////////////////////////////////////////
	// Mode classes.

	logic runClass;
	logic fullRun;
	logic stop01;
	logic stop2;
	logic inStop;
	logic deepOff;

	always_comb begin
		runClass = 1'b0;
		fullRun = 1'b0;
		stop01 = 1'b0;
		stop2 = 1'b0;
		deepOff = 1'b0;
		case (mode)
			MODE_RUN, MODE_SLEEP: begin
				runClass = 1'b1;
				fullRun = 1'b1;
			end
			MODE_LP_RUN, MODE_LP_SLEEP: begin
				runClass = 1'b1;
			end
			MODE_STOP0, MODE_STOP1: begin
				stop01 = 1'b1;
			end
			MODE_STOP2: begin
				stop2 = 1'b1;
			end
			MODE_STANDBY, MODE_SHUTDOWN: begin
				deepOff = 1'b1;
			end
			default: begin
				runClass = 1'b0;
			end
		endcase
		inStop = stop01 | stop2;
	end

	////////////////////////////////////////////////////////////////
	// On-demand fast oscillator, one slot per requester.

	for (genvar i = 0; i < `PG_NUM_OSC_REQ; i++) begin : g_osc
		osc_request_slot u_slot (
			.clk_sys(clk_sys),
			.rst(rst),
			.inStop(inStop),
			.capable(oscCapable[i]),
			.request(oscRequest[i]),
			.granted(fastOscGate[i])
		);
	end

	// The oscillator is on in stop only while some slot holds it.
	assign fastOscOn = |fastOscGate;

	////////////////////////////////////////////////////////////////
	// Peripheral run enables and wakeup routing.

	logic [`PG_NUM_SERIAL-1:0] serialDeep;
	logic [`PG_NUM_TWI-1:0] twiDeep;
	logic serialWake;
	logic twiWake;
	logic lptimWake;
	logic pinWake;

	always_comb begin
		serialDeep = '0;
		serialDeep[`PG_LPSERIAL_IDX] = 1'b1;
		twiDeep = '0;
		twiDeep[`PG_TWI_DEEP_IDX] = 1'b1;
		serialRun = {`PG_NUM_SERIAL{runClass | stop01}} |
			({`PG_NUM_SERIAL{stop2}} & serialDeep);
		twiRun = {`PG_NUM_TWI{runClass | stop01}} |
			({`PG_NUM_TWI{stop2}} & twiDeep);
		lptimRun[0] = swEn.lptimEn[0] & (runClass | inStop);
		lptimRun[1] = swEn.lptimEn[1] & (runClass | stop01);
		serialWake = inStop & |(serialEvent & serialRun);
		twiWake = inStop & |(twiAddrMatch & twiRun);
		lptimWake = inStop & |(lptimEvent & lptimRun);
		pinWake = deepOff & |wakePinEvent;
		// Tamper inputs are deliberately absent from every wake term.
		wakeupReq = serialWake | twiWake | lptimWake | pinWake |
			((runClass | inStop) & (extIrq | rtcEvent));
		if (mode == MODE_BATTERY) begin
			wakeupReq = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Memory, generator and optional functions.

	always_comb begin
		sram2Retain = (mode == MODE_STANDBY) ? swEn.sram2RetainSel :
			(runClass | inStop);
		rngAllow = swEn.rngEn & fullRun & coreRange1;
		dmaAllow = swEn.dmaEn & runClass;
		supplyDetAllow = swEn.supplyDetEn & (runClass | inStop);
		next_flashPowerDown = runClass ? swEn.flashPdReq : flashPowerDown;
		tamperActive = tamperIn;
		batterySupplied = {3{mode == MODE_BATTERY}};
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flashPowerDown <= `PG_FLASH_PD_RST;
		end else begin
			flashPowerDown <= next_flashPowerDown;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interconnect triggers.

	always_comb begin
		trigGate.timerSync = runClass;
		trigGate.convTrig = runClass;
		trigGate.memTrig = runClass;
		trigGate.compBlank = runClass;
		trigGate.timerBreak = fullRun;
		trigGate.compToLptim = {runClass | stop01,
			runClass | inStop};
		trigGate.rtcToLptim = {runClass | stop01,
			runClass | inStop};
		timerBreak = fullRun & |breakSrc;
	end

	////////////////////////////////////////////////////////////////
	// I/O state, reset pull-up and shutdown pull hold.

	always_comb begin
		next_ioAnalog = ioAnalog;
		next_resetPullupOn = resetPullupOn;
		// The hold is loaded together with the mode, so it is already gone
		// on the first cycle after the mode has left shutdown.
		next_pullCfgHold = 2'h0;
		if (next_mode == MODE_SHUTDOWN) begin
			next_pullCfgHold = pullCfgIn;
		end
		if (modeReq == MODE_RUN && mode == MODE_RUN) begin
			// Software reconfigures pins after boot; stay analog.
			next_ioAnalog = ioAnalog;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ioAnalog <= `PG_IO_ANALOG_RST;
			resetPullupOn <= !internalResetSrc;
			pullCfgHold <= 2'h0;
		end else begin
			ioAnalog <= next_ioAnalog;
			resetPullupOn <= next_resetPullupOn;
			pullCfgHold <= next_pullCfgHold;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks.

	rng_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
		rngAllow |-> (fullRun && coreRange1))
		else $error("random gen allowed outside run range 1");

	osc_only_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
		fastOscOn |-> $past(inStop))
		else $error("fast osc on outside stop");

	osc_release_a: assert property (@(posedge clk_sys) disable iff (rst)
		(oscRequest == '0) |=> !fastOscOn)
		else $error("fast osc not released");

	osc_exclusive_a: assert property (@(posedge clk_sys) disable iff (rst)
		fastOscGate[0] |-> $past(oscRequest[0]))
		else $error("osc gated to non-requester");

	battery_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
		!mainSupplyOk |=> mode == MODE_BATTERY)
		else $error("battery mode not entered");

	battery_nowake_a: assert property (@(posedge clk_sys) disable iff (rst)
		mode == MODE_BATTERY |-> !wakeupReq)
		else $error("wakeup in battery mode");

	timer_b_a: assert property (@(posedge clk_sys) disable iff (rst)
		stop2 |-> !lptimRun[1] && !trigGate.compToLptim[1])
		else $error("timer b active in stop 2");

	stop_trig_a: assert property (@(posedge clk_sys) disable iff (rst)
		inStop |-> !trigGate.timerSync && !timerBreak)
		else $error("timer link active in stop");

	sram_retain_a: assert property (@(posedge clk_sys) disable iff (rst)
		mode == MODE_STANDBY |-> sram2Retain == swEn.sram2RetainSel)
		else $error("retention select ignored");

	shutdown_pull_a: assert property (@(posedge clk_sys) disable iff (rst)
		(mode == MODE_SHUTDOWN ##1 mode != MODE_SHUTDOWN)
		|-> pullCfgHold == 2'h0)
		else $error("shutdown pull config kept");

	pullup_cut_a: assert property (@(posedge clk_sys)
		(rst && internalResetSrc) |=> !resetPullupOn)
		else $error("reset pull-up kept on internal reset");

	stop2_cov_c: cover property (@(posedge clk_sys) stop2 && wakeupReq);
	osc_cov_c: cover property (@(posedge clk_sys) inStop ##1 fastOscOn);
	batt_cov_c: cover property (@(posedge clk_sys)
		mode == MODE_BATTERY ##1 mode == MODE_RUN);

endmodule : power_mode_gating_wakeup

/* File: verification/osc_requester_model.sv */
`timescale 1ns/100ps

// Peripheral side of the on-demand oscillator. A one-cycle pulse on want
// starts a request that is held until the gate has been seen for HOLD cycles.
// A request that is never granted is held forever, as a real peripheral would.
module osc_requester_model
	import power_gating_pkg::*;
#(
	parameter int HOLD = 3
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] want,
	input wire logic [7:0] fastOscGate,
	output logic [7:0] oscRequest
);
	int served [8];

	always @(posedge clk_sys) begin
		for (int i = 0; i < 8; i++) begin
			if (rst) begin
				oscRequest[i] <= 1'b0;
				served[i] <= 0;
			end else if (want[i]) begin
				oscRequest[i] <= 1'b1;
				served[i] <= 0;
			end else if (oscRequest[i] && fastOscGate[i]) begin
				served[i] <= served[i] + 1;
				if (served[i] == HOLD - 1)
					oscRequest[i] <= 1'b0;
			end
		end
	end
endmodule : osc_requester_model

/* File: verification/tb_top.sv */
`timescale 1ns/100ps

module tb_top
	import power_gating_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	power_mode_t modeReq, mode;
	logic mainSupplyOk, coreRange1, internalResetSrc;
	sw_enable_t swEn;
	logic [7:0] oscCapable, oscRequest, fastOscGate, want;
	logic [5:0] serialEvent, serialRun;
	logic [2:0] twiAddrMatch, twiRun, tamperIn, tamperActive, batterySupplied;
	logic [1:0] lptimEvent, lptimRun, pullCfgIn, pullCfgHold;
	logic [4:0] wakePinEvent;
	logic [6:0] breakSrc;
	logic extIrq, rtcEvent, fastOscOn, wakeupReq, sram2Retain, rngAllow;
	logic flashPowerDown, dmaAllow, supplyDetAllow, ioAnalog, resetPullupOn;
	logic timerBreak;
	trigger_gate_t trigGate;
	int failures = 0;
	int total_checks = 0;

	// Expected gates per mode, RUN through SHUTDOWN, with all enables set.
	localparam logic [5:0] SER [9] = '{6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f,
		6'h3f, 6'h20, 6'h00, 6'h00};
	localparam logic [2:0] TWI [9] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
		3'h4, 3'h0, 3'h0};
	localparam logic [1:0] LPT [9] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3,
		2'h1, 2'h0, 2'h0};
	localparam logic [8:0] TRG [9] = '{9'h1ef, 9'h1ef, 9'h1ef, 9'h1ef,
		9'h00f, 9'h00f, 9'h005, 9'h000, 9'h000};
	localparam logic [2:0] ALW [9] = '{3'h7, 3'h7, 3'h5, 3'h5, 3'h1, 3'h1,
		3'h1, 3'h0, 3'h0};

	always #4 clk_sys = ~clk_sys;

	power_mode_gating_wakeup i_power_mode_gating_wakeup (.clk_sys(clk_sys),
		.rst(rst), .modeReq(modeReq), .mainSupplyOk(mainSupplyOk),
		.coreRange1(coreRange1), .swEn(swEn),
		.internalResetSrc(internalResetSrc), .oscCapable(oscCapable),
		.oscRequest(oscRequest), .serialEvent(serialEvent),
		.twiAddrMatch(twiAddrMatch), .lptimEvent(lptimEvent),
		.wakePinEvent(wakePinEvent), .extIrq(extIrq), .rtcEvent(rtcEvent),
		.tamperIn(tamperIn), .breakSrc(breakSrc), .pullCfgIn(pullCfgIn),
		.mode(mode), .fastOscOn(fastOscOn), .fastOscGate(fastOscGate),
		.serialRun(serialRun), .twiRun(twiRun), .lptimRun(lptimRun),
		.wakeupReq(wakeupReq), .sram2Retain(sram2Retain),
		.rngAllow(rngAllow), .flashPowerDown(flashPowerDown),
		.dmaAllow(dmaAllow), .supplyDetAllow(supplyDetAllow),
		.ioAnalog(ioAnalog), .resetPullupOn(resetPullupOn),
		.batterySupplied(batterySupplied), .tamperActive(tamperActive),
		.trigGate(trigGate), .timerBreak(timerBreak),
		.pullCfgHold(pullCfgHold));

	osc_requester_model #(.HOLD(3)) i_osc_requester_model (.clk_sys(clk_sys),
		.rst(rst), .want(want), .fastOscGate(fastOscGate),
		.oscRequest(oscRequest));

	////////////////////////////////////////////////////////////////////////

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task automatic setMode(input power_mode_t m);
		@(posedge clk_sys);
		modeReq <= m;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : setMode

	// Applies one set of wake sources and samples the request they cause.
	task automatic ev(input logic [5:0] s, input logic [2:0] t,
		input logic [1:0] l, input logic [4:0] p, input logic [2:0] tp,
		input logic ir, input logic e);
		@(posedge clk_sys);
		serialEvent <= s;
		twiAddrMatch <= t;
		lptimEvent <= l;
		wakePinEvent <= p;
		tamperIn <= tp;
		extIrq <= ir;
		rtcEvent <= ir;
		#1;
		check("wakeupReq", wakeupReq, e);
	endtask : ev

	// A grant that never comes or never goes is a hang: end the run.
	task automatic waitOsc(input logic lvl);
		int n;
		n = 0;
		while (fastOscOn !== lvl && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (fastOscOn !== lvl) begin
			failures++;
			results();
		end
	endtask : waitOsc

	task automatic pulseWant(input logic [7:0] w);
		@(posedge clk_sys);
		want <= w;
		@(posedge clk_sys);
		want <= 8'h00;
	endtask : pulseWant

	////////////////////////////////////////////////////////////////////////

	initial begin
		modeReq <= MODE_RUN;
		mainSupplyOk <= 1'b1;
		coreRange1 <= 1'b1;
		internalResetSrc <= 1'b0;
		swEn <= '0;
		oscCapable <= 8'h03;
		want <= 8'h00;
		breakSrc <= 7'h00;
		pullCfgIn <= 2'h2;
		ev('0, '0, '0, '0, '0, 1'b0, 1'b0);
		repeat (3) @(posedge clk_sys);
		#1;
		check("mode", mode, MODE_RUN);
		check("fastOscGate", fastOscGate, 8'h00);
		check("flashPowerDown", flashPowerDown, 1'b0);
		check("ioAnalog", ioAnalog, 1'b1);
		check("resetPullupOn", resetPullupOn, 1'b1);
		rst <= 1'b0;
		setMode(MODE_RUN);
		check("ioAnalog", ioAnalog, 1'b1);
		check("allow", {dmaAllow, rngAllow, supplyDetAllow}, 3'h0);
		$display("test reset done");

		swEn <= 7'h6f;
		for (int m = 0; m < 9; m++) begin
			setMode(power_mode_t'(m));
			check("serialRun", serialRun, SER[m]);
			check("twiRun", twiRun, TWI[m]);
			check("lptimRun", lptimRun, LPT[m]);
			check("trigGate", trigGate & 9'h1ef, TRG[m]);
			check("allow", {dmaAllow, rngAllow, supplyDetAllow}, ALW[m]);
		end
		check("pullCfgHold", pullCfgHold, 2'h2);
		setMode(MODE_RUN);
		check("pullCfgHold", pullCfgHold, 2'h0);
		coreRange1 <= 1'b0;
		breakSrc <= 7'h7f;
		setMode(MODE_RUN);
		check("rngAllow", rngAllow, 1'b0);
		check("timerBreak", timerBreak, 1'b1);
		coreRange1 <= 1'b1;
		setMode(MODE_STOP1);
		check("timerBreak", timerBreak, 1'b0);
		$display("test mode gates done");

		setMode(MODE_STOP2);
		ev(6'h01, '0, '0, '0, '0, 1'b0, 1'b0);
		ev(6'h20, '0, '0, '0, '0, 1'b0, 1'b1);
		ev('0, 3'h3, '0, '0, '0, 1'b0, 1'b0);
		ev('0, 3'h4, '0, '0, '0, 1'b0, 1'b1);
		ev('0, '0, 2'h2, '0, '0, 1'b0, 1'b0);
		ev('0, '0, 2'h1, '0, '0, 1'b0, 1'b1);
		ev('0, '0, '0, '0, 3'h7, 1'b0, 1'b0);
		for (int m = 7; m < 9; m++) begin
			setMode(power_mode_t'(m));
			for (int i = 0; i < 5; i++)
				ev('0, '0, '0, 5'(1 << i), '0, 1'b0, 1'b1);
			ev(6'h20, '0, 2'h1, '0, '0, 1'b0, 1'b0);
		end
		setMode(MODE_STANDBY);
		check("sram2Retain", sram2Retain, 1'b1);
		swEn.sram2RetainSel <= 1'b0;
		setMode(MODE_STANDBY);
		check("sram2Retain", sram2Retain, 1'b0);
		$display("test wakeup done");

		mainSupplyOk <= 1'b0;
		setMode(MODE_RUN);
		check("mode", mode, MODE_BATTERY);
		check("batterySupplied", batterySupplied, 3'h7);
		ev('0, '0, '0, '0, 3'h7, 1'b1, 1'b0);
		check("mode", mode, MODE_BATTERY);
		check("tamperActive", tamperActive, 3'h7);
		ev('0, '0, '0, '0, '0, 1'b0, 1'b0);
		mainSupplyOk <= 1'b1;
		swEn.flashPdReq <= 1'b1;
		setMode(MODE_RUN);
		check("flashPowerDown", flashPowerDown, 1'b1);
		$display("test battery done");

		// Slot 4 cannot wake from Stop, so its request must never be served.
		pulseWant(8'h12);
		repeat (4) @(posedge clk_sys);
		#1;
		check("fastOscGate", fastOscGate, 8'h00);
		setMode(MODE_STOP1);
		waitOsc(1'b1);
		check("fastOscOn", fastOscOn, 1'b1);
		check("fastOscGate", fastOscGate, 8'h02);
		waitOsc(1'b0);
		check("fastOscGate", fastOscGate, 8'h00);
		check("oscRequest", oscRequest[1], 1'b0);
		pulseWant(8'h01);
		waitOsc(1'b1);
		check("fastOscGate", fastOscGate, 8'h01);
		waitOsc(1'b0);
		check("fastOscOn", fastOscOn, 1'b0);
		$display("test oscillator done");

		// A reset from an inside source must cut the reset pin pull-up.
		@(posedge clk_sys);
		rst <= 1'b1;
		internalResetSrc <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check("resetPullupOn", resetPullupOn, 1'b0);
		check("flashPowerDown", flashPowerDown, 1'b0);
		check("ioAnalog", ioAnalog, 1'b1);
		rst <= 1'b0;
		setMode(MODE_RUN);
		check("resetPullupOn", resetPullupOn, 1'b0);
		check("mode", mode, MODE_RUN);
		$display("test internal reset done");
		results();
	end
endmodule : tb_top
